// ==== crie_top.sv ====
/*
 * CAN receiver interrupt enable logic: enable register, sticky event flags with
 * state flag capture, interrupt request outputs and the wake-up recovery request.
 * Assumes event pulses and state codes come from logic on the same clock, and a bus
 * master that never issues read and write strobes together.
 */
`timescale 1ns/1ps

// How it works
// - wake-up event flag with enable bit 7 set raises the wake-up request.
// - status-change flag with enable bit 6 set raises the error request.
// - receiver sensitivity bits 5-4 pick which receiver changes set status-change.
// - transmitter sensitivity bits 3-2 pick which transmitter changes set status-change.
// - receiver state flags track actual state, frozen while status-change is pending.
// - transmitter state flags track actual state, frozen while status-change is pending.
// - overrun flag with enable bit 1 set raises the error request.
// - receive-full flag with enable bit 0 set raises the receiver request.
// - stop or wait recovery only when wake enable and wake function both set.
// - transmitter leaving bus-off to OK forces the receiver state to OK.
// - each transmit empty flag has its own enable gating the transmit request.
module crie_top #(
    parameter int NTX = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [crie_pkg::ADDR_W-1:0] addr,
    input wire logic [crie_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [crie_pkg::DATA_W-1:0] rdata,
    input wire crie_pkg::crie_event_type events,
    input wire logic [1:0] rx_state_code,
    input wire logic [1:0] tx_state_code,
    input wire logic [NTX-1:0] tx_empty,
    output logic wake_irq,
    output logic err_irq,
    output logic rx_irq,
    output logic tx_irq,
    output logic irq,
    output logic wake_recover
);

    // ==========================================================
    // sensitivity decode, used for receiver and transmitter
    function automatic logic sens_hit(input logic [1:0] sens, input logic [1:0] old_c,
                                      input logic [1:0] new_c);
        logic hit;
        hit = 1'b0;
        unique case (sens)
            crie_pkg::SENS_NEVER: hit = 1'b0;
            crie_pkg::SENS_BUS_OFF:
                hit = (old_c == crie_pkg::ST_BUS_OFF) != (new_c == crie_pkg::ST_BUS_OFF);
            crie_pkg::SENS_ERR: hit = (old_c >= crie_pkg::ST_ERR) != (new_c >= crie_pkg::ST_ERR);
            crie_pkg::SENS_ALL: hit = (old_c != new_c);
        endcase
        return hit;
    endfunction

    // ==========================================================
    // state
    logic [7:0] en_ff;
    logic [7:0] nxt_en;
    logic [7:0] stat_ff;
    logic [7:0] nxt_stat;
    logic [NTX-1:0] tx_en_ff;
    logic [NTX-1:0] nxt_tx_en;
    logic wfe_ff;
    logic nxt_wfe;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic wake_irq_ff;
    logic nxt_wake_irq;
    logic err_irq_ff;
    logic nxt_err_irq;
    logic rx_irq_ff;
    logic nxt_rx_irq;
    logic tx_irq_ff;
    logic nxt_tx_irq;
    logic irq_ff;
    logic nxt_irq;
    logic recover_ff;
    logic nxt_recover;

    logic [7:0] clr;
    logic [7:0] set;
    logic [1:0] rx_eff;
    logic rx_hit;
    logic tx_hit;
    logic upd;

    // ==========================================================
    // next-state logic
    always_comb
    begin
        nxt_en = en_ff;
        nxt_tx_en = tx_en_ff;
        nxt_wfe = wfe_ff;
        clr = crie_pkg::ZERO_BYTE;
        if (wr)
        begin
            case (addr)
                crie_pkg::OFS_RX_EN: nxt_en = wdata;
                crie_pkg::OFS_FLAGS: clr = wdata & crie_pkg::W1C_MASK;
                crie_pkg::OFS_TX_EN: nxt_tx_en = wdata[NTX-1:0];
                crie_pkg::OFS_CTRL: nxt_wfe = wdata[crie_pkg::BIT_WFE];
                default: nxt_wfe = wfe_ff;
            endcase
        end
        // receiver skips to OK when transmitter recovers from bus-off
        if (stat_ff[crie_pkg::TXS_HI:crie_pkg::TXS_LO] == crie_pkg::ST_BUS_OFF &&
            tx_state_code == crie_pkg::ST_OK)
        begin
            rx_eff = crie_pkg::ST_OK;
        end
        else
        begin
            rx_eff = rx_state_code;
        end
        rx_hit = sens_hit(en_ff[crie_pkg::RXS_HI:crie_pkg::RXS_LO],
                          stat_ff[crie_pkg::RXS_HI:crie_pkg::RXS_LO], rx_eff);
        tx_hit = sens_hit(en_ff[crie_pkg::TXS_HI:crie_pkg::TXS_LO],
                          stat_ff[crie_pkg::TXS_HI:crie_pkg::TXS_LO], tx_state_code);
        upd = !stat_ff[crie_pkg::BIT_CSC];
        set = crie_pkg::ZERO_BYTE;
        set[crie_pkg::BIT_WAKE] = events.wake;
        set[crie_pkg::BIT_CSC] = upd && (rx_hit || tx_hit);
        set[crie_pkg::BIT_OVR] = events.overrun;
        set[crie_pkg::BIT_RXF] = events.rx_full;
        // set wins over a same-cycle clear
        nxt_stat = (stat_ff & ~clr) | set;
        if (upd)
        begin
            nxt_stat[crie_pkg::RXS_HI:crie_pkg::RXS_LO] = rx_eff;
            nxt_stat[crie_pkg::TXS_HI:crie_pkg::TXS_LO] = tx_state_code;
        end
        nxt_wake_irq = nxt_stat[crie_pkg::BIT_WAKE] & nxt_en[crie_pkg::BIT_WAKE];
        nxt_err_irq = (nxt_stat[crie_pkg::BIT_CSC] & nxt_en[crie_pkg::BIT_CSC]) |
                      (nxt_stat[crie_pkg::BIT_OVR] & nxt_en[crie_pkg::BIT_OVR]);
        nxt_rx_irq = nxt_stat[crie_pkg::BIT_RXF] & nxt_en[crie_pkg::BIT_RXF];
        nxt_tx_irq = |(tx_empty & nxt_tx_en);
        nxt_irq = nxt_wake_irq | nxt_err_irq | nxt_rx_irq | nxt_tx_irq;
        nxt_recover = nxt_wake_irq & nxt_wfe;
        nxt_rdata = crie_pkg::ZERO_BYTE;
        if (rd)
        begin
            case (addr)
                crie_pkg::OFS_RX_EN: nxt_rdata = en_ff;
                crie_pkg::OFS_FLAGS: nxt_rdata = stat_ff;
                crie_pkg::OFS_TX_EN: nxt_rdata[NTX-1:0] = tx_en_ff;
                crie_pkg::OFS_TX_EMPTY: nxt_rdata[NTX-1:0] = tx_empty;
                crie_pkg::OFS_CTRL: nxt_rdata = {7'h00, wfe_ff};
                default: nxt_rdata = crie_pkg::ZERO_BYTE;
            endcase
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            en_ff <= crie_pkg::EN_RST;
            stat_ff <= crie_pkg::FLAGS_RST;
            tx_en_ff <= '0;
            wfe_ff <= 1'b0;
            rdata_ff <= crie_pkg::ZERO_BYTE;
            wake_irq_ff <= 1'b0;
            err_irq_ff <= 1'b0;
            rx_irq_ff <= 1'b0;
            tx_irq_ff <= 1'b0;
            irq_ff <= 1'b0;
            recover_ff <= 1'b0;
        end
        else if (ce)
        begin
            en_ff <= nxt_en;
            stat_ff <= nxt_stat;
            tx_en_ff <= nxt_tx_en;
            wfe_ff <= nxt_wfe;
            rdata_ff <= nxt_rdata;
            wake_irq_ff <= nxt_wake_irq;
            err_irq_ff <= nxt_err_irq;
            rx_irq_ff <= nxt_rx_irq;
            tx_irq_ff <= nxt_tx_irq;
            irq_ff <= nxt_irq;
            recover_ff <= nxt_recover;
        end
    end

    assign rdata = rdata_ff;
    assign wake_irq = wake_irq_ff;
    assign err_irq = err_irq_ff;
    assign rx_irq = rx_irq_ff;
    assign tx_irq = tx_irq_ff;
    assign irq = irq_ff;
    assign wake_recover = recover_ff;

    // ==========================================================
    // checks
    AST_WAKE_IRQ:
    assert property (@(posedge clk) disable iff (rst)
        wake_irq == (stat_ff[crie_pkg::BIT_WAKE] && en_ff[crie_pkg::BIT_WAKE]))
    else $error("wake request does not match flag and enable");

    AST_CSC_ERR_IRQ:
    assert property (@(posedge clk) disable iff (rst)
        (stat_ff[crie_pkg::BIT_CSC] && en_ff[crie_pkg::BIT_CSC]) |-> err_irq)
    else $error("pending status change with enable gives no error request");

    AST_NO_SENS:
    assert property (@(posedge clk) disable iff (rst)
        (ce && en_ff[crie_pkg::RXS_HI:crie_pkg::RXS_LO] == crie_pkg::SENS_NEVER &&
         en_ff[crie_pkg::TXS_HI:crie_pkg::TXS_LO] == crie_pkg::SENS_NEVER &&
         !stat_ff[crie_pkg::BIT_CSC]) |=> !stat_ff[crie_pkg::BIT_CSC])
    else $error("status change set with both sensitivities off");

    AST_TX_BUS_OFF_SENS:
    assert property (@(posedge clk) disable iff (rst)
        (ce && !stat_ff[crie_pkg::BIT_CSC] &&
         en_ff[crie_pkg::TXS_HI:crie_pkg::TXS_LO] == crie_pkg::SENS_BUS_OFF &&
         stat_ff[crie_pkg::TXS_HI:crie_pkg::TXS_LO] == crie_pkg::ST_OK &&
         tx_state_code == crie_pkg::ST_BUS_OFF) |=> stat_ff[crie_pkg::BIT_CSC])
    else $error("transmitter bus-off entry missed");

    AST_RX_HOLD:
    assert property (@(posedge clk) disable iff (rst)
        (ce && stat_ff[crie_pkg::BIT_CSC]) |=> $stable(stat_ff[crie_pkg::RXS_HI:crie_pkg::RXS_LO]))
    else $error("receiver flags changed while status change pending");

    AST_TX_TRACK:
    assert property (@(posedge clk) disable iff (rst)
        (ce && !stat_ff[crie_pkg::BIT_CSC]) |=>
        stat_ff[crie_pkg::TXS_HI:crie_pkg::TXS_LO] == $past(tx_state_code))
    else $error("transmitter flags do not track state");

    AST_OVR_ERR_IRQ:
    assert property (@(posedge clk) disable iff (rst)
        (stat_ff[crie_pkg::BIT_OVR] && en_ff[crie_pkg::BIT_OVR]) |-> err_irq)
    else $error("overrun with enable gives no error request");

    AST_RX_IRQ:
    assert property (@(posedge clk) disable iff (rst)
        rx_irq == (stat_ff[crie_pkg::BIT_RXF] && en_ff[crie_pkg::BIT_RXF]))
    else $error("receiver request does not match flag and enable");

    AST_RECOVER:
    assert property (@(posedge clk) disable iff (rst)
        wake_recover |-> (wfe_ff && en_ff[crie_pkg::BIT_WAKE] && stat_ff[crie_pkg::BIT_WAKE]))
    else $error("recovery without both wake enables");

    AST_RX_FORCE:
    assert property (@(posedge clk) disable iff (rst)
        (ce && !stat_ff[crie_pkg::BIT_CSC] &&
         stat_ff[crie_pkg::TXS_HI:crie_pkg::TXS_LO] == crie_pkg::ST_BUS_OFF &&
         tx_state_code == crie_pkg::ST_OK) |=>
        stat_ff[crie_pkg::RXS_HI:crie_pkg::RXS_LO] == crie_pkg::ST_OK)
    else $error("receiver not forced to OK on bus-off recovery");

    AST_TX_IRQ:
    assert property (@(posedge clk) disable iff (rst)
        ce |=> (tx_irq == (|($past(tx_empty) & tx_en_ff))))
    else $error("transmit request does not follow empty flags and enables");

    AST_IRQ_DROP:
    assert property (@(posedge clk) disable iff (rst)
        $fell(rx_irq) |-> (!stat_ff[crie_pkg::BIT_RXF] || !en_ff[crie_pkg::BIT_RXF]))
    else $error("receiver request dropped while flag and enable set");

    AST_ERR_IRQ_EXACT:
    assert property (@(posedge clk) disable iff (rst)
        err_irq == ((stat_ff[crie_pkg::BIT_CSC] && en_ff[crie_pkg::BIT_CSC]) ||
                    (stat_ff[crie_pkg::BIT_OVR] && en_ff[crie_pkg::BIT_OVR])))
    else $error("error request does not match flags and enables");

    AST_IRQ_OR:
    assert property (@(posedge clk) disable iff (rst)
        irq == (wake_irq || err_irq || rx_irq || tx_irq))
    else $error("summary request is not the OR of the four requests");

    AST_RECOVER_SET:
    assert property (@(posedge clk) disable iff (rst)
        wake_recover == (wake_irq && wfe_ff))
    else $error("recovery request does not follow wake request and function enable");

    AST_RX_TRACK:
    assert property (@(posedge clk) disable iff (rst)
        (ce && !stat_ff[crie_pkg::BIT_CSC] &&
         stat_ff[crie_pkg::TXS_HI:crie_pkg::TXS_LO] != crie_pkg::ST_BUS_OFF) |=>
        stat_ff[crie_pkg::RXS_HI:crie_pkg::RXS_LO] == $past(rx_state_code))
    else $error("receiver flags do not track state");

    AST_TX_HOLD:
    assert property (@(posedge clk) disable iff (rst)
        (ce && stat_ff[crie_pkg::BIT_CSC]) |=> $stable(stat_ff[crie_pkg::TXS_HI:crie_pkg::TXS_LO]))
    else $error("transmitter flags changed while status change pending");

    AST_RX_BUS_OFF_SENS:
    assert property (@(posedge clk) disable iff (rst)
        (ce && !stat_ff[crie_pkg::BIT_CSC] &&
         en_ff[crie_pkg::RXS_HI:crie_pkg::RXS_LO] == crie_pkg::SENS_BUS_OFF &&
         stat_ff[crie_pkg::RXS_HI:crie_pkg::RXS_LO] == crie_pkg::ST_OK &&
         stat_ff[crie_pkg::TXS_HI:crie_pkg::TXS_LO] != crie_pkg::ST_BUS_OFF &&
         rx_state_code == crie_pkg::ST_BUS_OFF) |=> stat_ff[crie_pkg::BIT_CSC])
    else $error("receiver bus-off entry missed");

    AST_WAKE_STICKY:
    assert property (@(posedge clk) disable iff (rst)
        (ce && events.wake) |=> stat_ff[crie_pkg::BIT_WAKE])
    else $error("wake event did not set its flag");

    AST_FLAG_HOLD:
    assert property (@(posedge clk) disable iff (rst)
        (ce && stat_ff[crie_pkg::BIT_RXF] &&
         !(wr && addr == crie_pkg::OFS_FLAGS && wdata[crie_pkg::BIT_RXF])) |=>
        stat_ff[crie_pkg::BIT_RXF])
    else $error("receive-full flag dropped without a clear");

endmodule

// ==== crie_pkg.sv ====
/*
 * Constants, register map and carrier types for the CAN receiver interrupt enable block.
 * Assumes a single 40 MHz clock domain shared with the protocol engine.
 */
package crie_pkg;
    // ==========================================================
    // register bus
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam logic [2:0] OFS_RX_EN = 3'h0;
    localparam logic [2:0] OFS_FLAGS = 3'h1;
    localparam logic [2:0] OFS_TX_EN = 3'h2;
    localparam logic [2:0] OFS_TX_EMPTY = 3'h3;
    localparam logic [2:0] OFS_CTRL = 3'h4;
    // ==========================================================
    // field positions, shared by enable and flag registers; BIT_WFE is in the control register
    localparam int BIT_WAKE = 7;
    localparam int BIT_CSC = 6;
    localparam int RXS_HI = 5;
    localparam int RXS_LO = 4;
    localparam int TXS_HI = 3;
    localparam int TXS_LO = 2;
    localparam int BIT_OVR = 1;
    localparam int BIT_RXF = 0;
    localparam int BIT_WFE = 0;
    localparam logic [7:0] W1C_MASK = 8'hC3;
    localparam logic [7:0] EN_RST = 8'h00;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // ==========================================================
    // error state codes and sensitivity levels
    localparam logic [1:0] ST_OK = 2'h0;
    localparam logic [1:0] ST_WARN = 2'h1;
    localparam logic [1:0] ST_ERR = 2'h2;
    localparam logic [1:0] ST_BUS_OFF = 2'h3;
    localparam logic [1:0] SENS_NEVER = 2'h0;
    localparam logic [1:0] SENS_BUS_OFF = 2'h1;
    localparam logic [1:0] SENS_ERR = 2'h2;
    localparam logic [1:0] SENS_ALL = 2'h3;
    // ==========================================================
    // one-cycle event pulses from the protocol engine
    typedef struct packed {
        logic wake;
        logic overrun;
        logic rx_full;
    } crie_event_type;
endpackage

// ==== crie_engine_model.sv ====
/*
 * Stand-in for the protocol engine: event pulses, error state codes, empty flags.
 * Assumes the bench calls its tasks from one process, one call at a time.
 */
`timescale 1ns/1ps
module crie_engine_model #(
    parameter int NTX = 3
) (
    input wire logic clk,
    output crie_pkg::crie_event_type events,
    output logic [1:0] rx_state_code,
    output logic [1:0] tx_state_code,
    output logic [NTX-1:0] tx_empty
);
    initial
    begin
        events = 3'h0;
        rx_state_code = 2'h0;
        tx_state_code = 2'h0;
        tx_empty = '0;
    end

    // ==========================================================
    // one-cycle pulse, launched just after an edge
    task automatic pulse(input logic [2:0] e);
        @(posedge clk);
        events <= e;
        @(posedge clk);
        events <= 3'h0;
    endtask

    task automatic set_codes(input logic [1:0] r, input logic [1:0] t);
        @(posedge clk);
        rx_state_code <= r;
        tx_state_code <= t;
    endtask

    task automatic set_empty(input logic [NTX-1:0] e);
        @(posedge clk);
        tx_empty <= e;
    endtask
endmodule

// ==== test_crie_top.sv ====
/*
 * Self-checking bench for the receiver interrupt enable block.
 * Assumes the engine model drives events and state codes; ce is high but for one freeze test.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        total_checks++; \
        if ((g) !== (e)) \
        begin \
            n_mismatch++; \
            $display("[ERR] %s exp %h got %h", nm, e, g); \
        end \
    end
module test_crie_top;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic ce = 1'h1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'h0;
    logic rd = 1'h0;
    logic [7:0] rdata;
    crie_pkg::crie_event_type events;
    logic [1:0] rx_code;
    logic [1:0] tx_code;
    logic [2:0] tx_empty;
    logic wake_irq, err_irq, rx_irq, tx_irq, irq, wake_recover;
    int n_mismatch = 0;
    int total_checks = 0;
    logic [1:0] tr_o[5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h3};
    logic [1:0] tr_n[5] = '{2'h1, 2'h2, 2'h0, 2'h3, 2'h0};
    logic [7:0] ebit[3] = '{8'h01, 8'h02, 8'h80};
    logic [5:0] eout[3] = '{6'h05, 6'h09, 6'h11};

    always #12.5 clk = ~clk;

    crie_top #(.NTX(3)) u_crie_top (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .events(events),
        .rx_state_code(rx_code), .tx_state_code(tx_code), .tx_empty(tx_empty),
        .wake_irq(wake_irq), .err_irq(err_irq), .rx_irq(rx_irq), .tx_irq(tx_irq),
        .irq(irq), .wake_recover(wake_recover));

    crie_engine_model #(.NTX(3)) u_crie_engine_model (.clk(clk), .events(events),
        .rx_state_code(rx_code), .tx_state_code(tx_code), .tx_empty(tx_empty));

    // ==========================================================
    // register bus and checks
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'h0;
    endtask

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e, input string nm);
        @(posedge clk);
        rd <= 1'h1;
        addr <= a;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        `CHK(nm, e, rdata)
    endtask

    // vector is recover, wake, err, rx, tx, irq
    task automatic out_chk(input logic [5:0] e, input string nm);
        repeat (2) @(posedge clk);
        #1;
        `CHK(nm, e, {wake_recover, wake_irq, err_irq, rx_irq, tx_irq, irq})
    endtask

    task automatic drive(input int t, input logic [1:0] v);
        u_crie_engine_model.set_codes(t ? 2'h0 : v, t ? v : 2'h0);
    endtask

    function automatic logic csc_exp(input logic [1:0] s, input logic [1:0] o,
        input logic [1:0] n);
        case (s)
            2'h1: return (o == 2'h3) != (n == 2'h3);
            2'h2: return o[1] != n[1];
            2'h3: return o != n;
            default: return 1'h0;
        endcase
    endfunction

    task automatic sens_case(input int t, input logic [1:0] s, input logic [1:0] o,
        input logic [1:0] n);
        logic c;
        logic [7:0] f;
        c = csc_exp(s, o, n);
        f = {1'h0, c, 6'h00} | (8'(n) << (t ? 2 : 4));
        wr_reg(crie_pkg::OFS_RX_EN, 8'h00);
        drive(t, o);
        wr_reg(crie_pkg::OFS_FLAGS, 8'hFF);
        wr_reg(crie_pkg::OFS_RX_EN, 8'h40 | (8'(s) << (t ? 2 : 4)));
        drive(t, n);
        repeat (2) @(posedge clk);
        rd_chk(crie_pkg::OFS_FLAGS, f, "state flags");
        `CHK("err_irq", c, err_irq)
        if (c)
        begin
            drive(t, o);
            repeat (2) @(posedge clk);
            rd_chk(crie_pkg::OFS_FLAGS, f, "frozen flags");
            drive(t, n);
        end
    endtask

    task automatic end_of_test();
        if (n_mismatch == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (50000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        wr_reg(3'h5, 8'hFF);
        for (int a = 0; a < 8; a++)
            rd_chk(3'(a), 8'h00, "reset value");
        for (int i = 0; i < 3; i++)
        begin
            wr_reg(crie_pkg::OFS_RX_EN, 8'h00);
            u_crie_engine_model.pulse(3'h1 << i);
            out_chk(6'h00, "masked event");
            rd_chk(crie_pkg::OFS_FLAGS, ebit[i], "sticky flag");
            wr_reg(crie_pkg::OFS_RX_EN, ebit[i]);
            out_chk(eout[i], "request");
            wr_reg(crie_pkg::OFS_CTRL, 8'h01);
            out_chk(eout[i] | {i == 2, 5'h00}, "recover");
            wr_reg(crie_pkg::OFS_CTRL, 8'h00);
            wr_reg(crie_pkg::OFS_FLAGS, ebit[i]);
            out_chk(6'h00, "cleared");
        end
        for (int t = 0; t < 2; t++)
            for (int s = 0; s < 4; s++)
                for (int k = 0; k < 5; k++)
                    sens_case(t, 2'(s), tr_o[k], tr_n[k]);
        wr_reg(crie_pkg::OFS_RX_EN, 8'h00);
        u_crie_engine_model.set_codes(2'h2, 2'h3);
        wr_reg(crie_pkg::OFS_FLAGS, 8'hFF);
        wr_reg(crie_pkg::OFS_RX_EN, 8'h70);
        u_crie_engine_model.set_codes(2'h2, 2'h0);
        repeat (2) @(posedge clk);
        rd_chk(crie_pkg::OFS_FLAGS, 8'h40, "bus-off exit");
        drive(0, 2'h0);
        wr_reg(crie_pkg::OFS_FLAGS, 8'hFF);
        wr_reg(crie_pkg::OFS_RX_EN, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            u_crie_engine_model.set_empty(3'h1 << i);
            wr_reg(crie_pkg::OFS_TX_EN, ~(8'h01 << i));
            out_chk(6'h00, "tx masked");
            rd_chk(crie_pkg::OFS_TX_EMPTY, 8'h01 << i, "tx empty");
            wr_reg(crie_pkg::OFS_TX_EN, 8'h01 << i);
            out_chk(6'h03, "tx request");
        end
        wr_reg(crie_pkg::OFS_RX_EN, 8'h01);
        @(posedge clk);
        ce <= 1'h0;
        u_crie_engine_model.pulse(3'h1);
        out_chk(6'h03, "frozen outputs");
        @(posedge clk);
        ce <= 1'h1;
        rd_chk(crie_pkg::OFS_FLAGS, 8'h00, "event lost while frozen");
        end_of_test();
    end
endmodule
